// ===== verilog/tbap_access_port.sv
// byte-wide cpu access to the 16-bit registers of the free running timer unit
// assumes cpu strobes and the timer values are on ref_clk, 25 MHz
//
// Notes on behaviour
// - counter, two compares, capture are 16-bit, reached bytewise via one latch
// - high-byte write goes into the latch only, target untouched
// - low-byte write loads target with latched high and new low at once
// - high-byte read of counter or capture returns high, latches low byte
// - following low-byte read returns the latched byte, not the live one
// - compare reads come straight from the register, latch untouched
`timescale 1ns/1ps
`include "tbap_defs.svh"

module tbap_access_port
   import tbap_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input tbap_sel_t cpu_sel,
   input wire logic cpu_byte_hi,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_rvalid,
   input wire logic [15:0] free_running_count,
   input wire logic [15:0] output_compare_a,
   input wire logic [15:0] output_compare_b,
   input wire logic [15:0] input_capture_value,
   output logic [15:0] load_data,
   output logic load_count,
   output logic load_compare_a,
   output logic load_compare_b,
   output logic load_capture
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // the two byte fields must tile the 16-bit word, high above low
   if (((`TBAP_HI_MSB - `TBAP_HI_LSB) != 7) || ((`TBAP_LO_MSB - `TBAP_LO_LSB) != 7)
      || (`TBAP_HI_LSB != (`TBAP_LO_MSB + 1))) begin : g_field_check
      $error("byte fields do not tile the 16-bit word");
   end

   // the select decode covers exactly four targets
   if ($bits(tbap_sel_t) != 2) begin : g_sel_check
      $error("register select must be two bits wide");
   end

   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   logic wr_hi;
   logic wr_lo;
   logic rd_go;
   logic via_latch;
   logic latch_load;
   logic [7:0] latch_din;
   logic [7:0] latch_q;
   logic [15:0] live_word;

   // a write and a read in the same cycle: the write is served
   assign wr_hi = cpu_wr && cpu_byte_hi;
   assign wr_lo = cpu_wr && !cpu_byte_hi;
   assign rd_go = cpu_rd && !cpu_wr;
   assign via_latch = (cpu_sel == TBAP_SEL_COUNT) || (cpu_sel == TBAP_SEL_CAPTURE);

   always_comb begin
      unique case (cpu_sel)
         TBAP_SEL_COUNT: live_word = free_running_count;
         TBAP_SEL_CMP_A: live_word = output_compare_a;
         TBAP_SEL_CMP_B: live_word = output_compare_b;
         TBAP_SEL_CAPTURE: live_word = input_capture_value;
      endcase
   end

   // ------------------------------------------------------------
   // holding latch
   // ------------------------------------------------------------
   // compare reads never touch it
   assign latch_load = wr_hi || (rd_go && cpu_byte_hi && via_latch);
   assign latch_din = wr_hi ? cpu_wdata : live_word[`TBAP_LO_MSB:`TBAP_LO_LSB];

   tbap_byte_latch u_latch (
      .ref_clk(ref_clk),
      .reset(reset),
      .load(latch_load),
      .din(latch_din),
      .dout(latch_q)
   );

   // ------------------------------------------------------------
   // write path
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         load_data <= `TBAP_WORD_RST;
      end else if (wr_lo) begin
         load_data <= {latch_q, cpu_wdata};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         load_count <= 1'b0;
         load_compare_a <= 1'b0;
         load_compare_b <= 1'b0;
         load_capture <= 1'b0;
      end else begin
         // only the low byte commits; high byte leaves target alone
         load_count <= wr_lo && (cpu_sel == TBAP_SEL_COUNT);
         load_compare_a <= wr_lo && (cpu_sel == TBAP_SEL_CMP_A);
         load_compare_b <= wr_lo && (cpu_sel == TBAP_SEL_CMP_B);
         load_capture <= wr_lo && (cpu_sel == TBAP_SEL_CAPTURE);
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cpu_rdata <= `TBAP_LATCH_RST;
      end else if (rd_go) begin
         if (cpu_byte_hi) begin
            cpu_rdata <= live_word[`TBAP_HI_MSB:`TBAP_HI_LSB];
         end else if (via_latch) begin
            cpu_rdata <= latch_q;
         end else begin
            cpu_rdata <= live_word[`TBAP_LO_MSB:`TBAP_LO_LSB];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cpu_rvalid <= 1'b0;
      end else begin
         cpu_rvalid <= rd_go;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_hi_read_latched;
      rd_go && cpu_byte_hi && via_latch;
   endsequence

   sequence s_lo_read_latched;
      rd_go && !cpu_byte_hi && via_latch;
   endsequence

   sequence s_hi_write_a;
      wr_hi && cpu_sel == TBAP_SEL_CMP_A;
   endsequence

   sequence s_lo_write_a;
      wr_lo && cpu_sel == TBAP_SEL_CMP_A;
   endsequence

   // the checks below, AST_ONE_LOAD aside, watch the port outputs and the latch one cycle after the strobe

   AST_ONE_LOAD: assert property (
      $onehot0({load_count, load_compare_a, load_compare_b, load_capture}))
      else $error("more than one target loaded at once");

   AST_HI_WRITE_NO_LOAD: assert property (
      wr_hi |=> !(load_count || load_compare_a || load_compare_b || load_capture))
      else $error("high byte write loaded a target");

   AST_HI_WRITE_LATCH: assert property (
      wr_hi |=> latch_q == $past(cpu_wdata))
      else $error("high byte write not held in latch");

   AST_PAIR_WRITE: assert property (
      s_hi_write_a ##1 s_lo_write_a
      |=> load_compare_a && load_data == {$past(cpu_wdata, 2), $past(cpu_wdata)})
      else $error("pair write did not load combined word");

   AST_HI_READ: assert property (
      s_hi_read_latched |=> cpu_rvalid && cpu_rdata == $past(live_word[15:8])
      && latch_q == $past(live_word[7:0]))
      else $error("high byte read wrong or low byte not latched");

   AST_LO_READ: assert property (
      s_hi_read_latched ##1 s_lo_read_latched
      |=> cpu_rvalid && cpu_rdata == $past(live_word[7:0], 2))
      else $error("low byte read did not come from latch");

   AST_CMP_READ: assert property (
      (rd_go && !via_latch) |=> $stable(latch_q)
      && cpu_rdata == ($past(cpu_byte_hi) ? $past(live_word[15:8]) : $past(live_word[7:0])))
      else $error("compare read not direct or latch disturbed");

   // any low-byte write commits one target with latch as the high half
   AST_LO_WRITE_LOAD: assert property (
      wr_lo |=> $onehot({load_count, load_compare_a, load_compare_b, load_capture})
      && load_data == {$past(latch_q), $past(cpu_wdata)})
      else $error("low byte write did not load latch and byte");

   // reads never commit a target
   AST_READ_NO_LOAD: assert property (
      !cpu_wr |=> !(load_count || load_compare_a || load_compare_b || load_capture))
      else $error("target loaded without a write");

   // a write, with or without a read beside it, gives no read answer
   AST_WRITE_NO_ANSWER: assert property (
      cpu_wr |=> !cpu_rvalid)
      else $error("read answered in a write cycle");

   // an accepted read is always answered one cycle later
   AST_READ_ANSWER: assert property (
      (cpu_rd && !cpu_wr) |=> cpu_rvalid)
      else $error("accepted read got no answer");

   // only a high-byte access may move the latch
   AST_LATCH_QUIET: assert property (
      !cpu_byte_hi |=> $stable(latch_q))
      else $error("latch moved without a high byte access");

endmodule

// ===== verilog/tbap_defs.svh
// constants for the byte access port of the free running timer unit
// assumes inclusion by bare name from the design files
`ifndef TBAP_DEFS_SVH
`define TBAP_DEFS_SVH

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TBAP_HI_MSB 15
`define TBAP_HI_LSB 8
`define TBAP_LO_MSB 7
`define TBAP_LO_LSB 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TBAP_LATCH_RST 8'h00
`define TBAP_WORD_RST 16'h0000

// ------------------------------------------------------------
// timing counts, in ref_clk cycles
// ------------------------------------------------------------
`define TBAP_READ_LATENCY 1

`endif

// ===== verilog/tbap_pkg.sv
// types for the byte access port of the free running timer unit
// assumes nothing of its surroundings
package tbap_pkg;

   // register selected by the cpu access
   typedef enum logic [1:0] {
      TBAP_SEL_COUNT,
      TBAP_SEL_CMP_A,
      TBAP_SEL_CMP_B,
      TBAP_SEL_CAPTURE
   } tbap_sel_t;

endpackage

// ===== verilog/tbap_byte_latch.sv
// the shared 8-bit holding latch
// assumes a synchronous active-high reset on ref_clk
`timescale 1ns/1ps
`include "tbap_defs.svh"

module tbap_byte_latch (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [7:0] din,
   output logic [7:0] dout
);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dout <= `TBAP_LATCH_RST;
      end else if (load) begin
         dout <= din;
      end
   end

endmodule

// ===== bench/tbap_timer_model.sv
// model of the timer values behind the access port
// assumes load pulses from the port on ref_clk
`timescale 1ns/1ps
module tbap_timer_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [15:0] load_data,
   input wire logic load_count,
   input wire logic load_compare_a,
   input wire logic load_compare_b,
   input wire logic load_capture,
   output logic [15:0] free_running_count,
   output logic [15:0] output_compare_a,
   output logic [15:0] output_compare_b,
   output logic [15:0] input_capture_value
);
   // ---------------------------------------
   // values, count runs every cycle
   // ---------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         free_running_count <= 16'h0000;
         output_compare_a <= 16'hFFFF;
         output_compare_b <= 16'hFFFF;
         input_capture_value <= 16'h0000;
      end else begin
         free_running_count <= load_count ? load_data : free_running_count + 16'h0001;
         if (load_compare_a) output_compare_a <= load_data;
         if (load_compare_b) output_compare_b <= load_data;
         if (load_capture) input_capture_value <= load_data;
      end
   end
endmodule

// ===== bench/test_timer_byte_access_port.sv
// bench for the byte access port
// assumes the timer model stands behind the port
`timescale 1ns/1ps
module test_timer_byte_access_port;
   import tbap_pkg::*;
   typedef struct {tbap_sel_t sel; logic [15:0] w;} tbap_row_t;
   logic ref_clk, reset, cpu_byte_hi, cpu_wr, cpu_rd, cpu_rvalid, ld_c, ld_a, ld_b, ld_p;
   tbap_sel_t cpu_sel;
   logic [7:0] cpu_wdata, cpu_rdata;
   logic [15:0] cnt, cmp_a, cmp_b, cap, load_data, snap, got, keep;
   int fails, tests_run;
   tbap_row_t rows[4] = '{'{TBAP_SEL_COUNT, 16'hA5F0}, '{TBAP_SEL_CMP_A, 16'h12C3},
      '{TBAP_SEL_CMP_B, 16'h7E81}, '{TBAP_SEL_CAPTURE, 16'h0F5A}};
   tbap_access_port u_dut (.ref_clk(ref_clk), .reset(reset), .cpu_sel(cpu_sel),
      .cpu_byte_hi(cpu_byte_hi), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .free_running_count(cnt),
      .output_compare_a(cmp_a), .output_compare_b(cmp_b), .input_capture_value(cap),
      .load_data(load_data), .load_count(ld_c), .load_compare_a(ld_a),
      .load_compare_b(ld_b), .load_capture(ld_p));
   tbap_timer_model u_model (.ref_clk(ref_clk), .reset(reset), .load_data(load_data),
      .load_count(ld_c), .load_compare_a(ld_a), .load_compare_b(ld_b), .load_capture(ld_p),
      .free_running_count(cnt), .output_compare_a(cmp_a), .output_compare_b(cmp_b),
      .input_capture_value(cap));
   // ---------------------------------------
   // helpers
   // ---------------------------------------
   task chk(string n, logic [15:0] e, logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task strobe(tbap_sel_t s, logic hi, logic w, logic r, logic [7:0] d);
      @(negedge ref_clk);
      cpu_sel = s;
      cpu_byte_hi = hi;
      cpu_wr = w;
      cpu_rd = r;
      cpu_wdata = d;
   endtask
   task wr_pair(tbap_sel_t s, logic [15:0] w);
      strobe(s, 1'b1, 1'b1, 1'b0, w[15:8]);
      strobe(s, 1'b0, 1'b1, 1'b0, w[7:0]);
      chk("load_after_hi", 16'h0000, {ld_c, ld_a, ld_b, ld_p});
      strobe(s, 1'b0, 1'b0, 1'b0, 8'h00);
      chk("load_data", w, load_data);
      chk("load_sel", 16'h0008 >> s, {ld_c, ld_a, ld_b, ld_p});
   endtask
   task rd_pair(tbap_sel_t s);
      strobe(s, 1'b1, 1'b0, 1'b1, 8'h00);
      snap = (s == TBAP_SEL_COUNT) ? cnt : (s == TBAP_SEL_CMP_A) ? cmp_a :
         (s == TBAP_SEL_CMP_B) ? cmp_b : cap;
      strobe(s, 1'b0, 1'b0, 1'b1, 8'h00);
      chk("rvalid_hi", 16'h0001, cpu_rvalid);
      got[15:8] = cpu_rdata;
      strobe(s, 1'b0, 1'b0, 1'b0, 8'h00);
      chk("rvalid_lo", 16'h0001, cpu_rvalid);
      got[7:0] = cpu_rdata;
   endtask
   task give_verdict();
      if (fails == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ---------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      #20000;
      fails++;
      give_verdict();
   end
   initial begin
      fails = 0;
      tests_run = 0;
      reset = 1'b1;
      cpu_sel = TBAP_SEL_COUNT;
      {cpu_byte_hi, cpu_wr, cpu_rd, cpu_wdata} = '0;
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      chk("rst_out", 16'h0000, {cpu_rdata, cpu_rvalid} | load_data);
      strobe(TBAP_SEL_COUNT, 1'b0, 1'b0, 1'b1, 8'h00);
      strobe(TBAP_SEL_COUNT, 1'b0, 1'b0, 1'b0, 8'h00);
      chk("latch_rst", 16'h0000, cpu_rdata);
      // pairs never interleaved
      foreach (rows[i]) begin
         wr_pair(rows[i].sel, rows[i].w);
         rd_pair(rows[i].sel);
         chk("word", (rows[i].sel == TBAP_SEL_COUNT) ? snap : rows[i].w, got);
      end
      // compare pair between count halves keeps the latch
      strobe(TBAP_SEL_COUNT, 1'b1, 1'b0, 1'b1, 8'h00);
      keep = cnt;
      rd_pair(TBAP_SEL_CMP_A);
      chk("cmp_direct", 16'h12C3, got);
      strobe(TBAP_SEL_COUNT, 1'b0, 1'b0, 1'b1, 8'h00);
      strobe(TBAP_SEL_COUNT, 1'b0, 1'b0, 1'b0, 8'h00);
      chk("latch_kept", {8'h00, keep[7:0]}, cpu_rdata);
      // read with write in one cycle is dropped
      strobe(TBAP_SEL_CMP_B, 1'b0, 1'b1, 1'b1, 8'h77);
      strobe(TBAP_SEL_CMP_B, 1'b0, 1'b0, 1'b0, 8'h00);
      chk("rvalid_drop", 16'h0000, cpu_rvalid);
      give_verdict();
   end
endmodule
